// ==== hdl/afc_bcr_pkg.sv ====
package afc_bcr_pkg;
  // register offsets
  localparam logic [7:0] OFF_AFC_CONFIG    = 8'h1D;
  localparam logic [7:0] OFF_AFC_WAIT      = 8'h1E;
  localparam logic [7:0] OFF_GEARSHIFT     = 8'h1F;
  localparam logic [7:0] OFF_OSR_LOW       = 8'h20;
  localparam logic [7:0] OFF_OFFSET_UPPER  = 8'h21;
  localparam logic [7:0] OFF_OFFSET_MIDDLE = 8'h22;
  localparam logic [7:0] OFF_OFFSET_LOWER  = 8'h23;
  localparam logic [7:0] OFF_GAIN_UPPER    = 8'h24;
  localparam logic [7:0] OFF_GAIN_LOWER    = 8'h25;
  // reset values
  localparam logic [7:0] RST_AFC_CONFIG    = 8'h40;
  localparam logic [7:0] RST_AFC_WAIT      = 8'h0A;
  localparam logic [7:0] RST_GEARSHIFT     = 8'h03;
  localparam logic [7:0] RST_OSR_LOW       = 8'h64;
  localparam logic [7:0] RST_OFFSET_UPPER  = 8'h01;
  localparam logic [7:0] RST_OFFSET_MIDDLE = 8'h47;
  localparam logic [7:0] RST_OFFSET_LOWER  = 8'hAE;
  localparam logic [7:0] RST_GAIN_UPPER    = 8'h00;
  localparam logic [7:0] RST_GAIN_LOWER    = 8'h8F;
  // field positions
  localparam int AFC_HALVE_BIT  = 7;
  localparam int AFC_ENABLE_BIT = 6;
  localparam int GEAR_HI_LSB    = 3;
  localparam int GEAR_LO_LSB    = 0;
  localparam int SHWAIT_LSB     = 3;
  localparam int LGWAIT_LSB     = 0;
  localparam int PHASE_BIT      = 7;
  localparam int RX_READY_BIT   = 6;
  localparam int CRFAST_LSB     = 3;
  localparam int CRSLOW_LSB     = 0;
  localparam int OSR_HI_LSB     = 5;
  localparam int STALL_BIT      = 4;
  localparam int NCO_HI_LSB     = 0;
  localparam int GAIN_HI_LSB    = 0;
  // timing: one bit at 40 kbps, clock period 10 ns
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BIT_PERIOD_NS  = 25000;
  localparam int BIT_CYCLES     = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BITS_PER_WAIT  = 2;
  // default tolerated afc frequency error, arbitrary units
  localparam logic [7:0] AFC_TOL_DEFAULT = 8'h40;
  typedef enum logic [1:0] {
    PH_SEARCH = 2'b01,
    PH_LOCKED = 2'b10
  } phase_t;
endpackage

// ==== hdl/afc_bit_clock_recovery_cfg.sv ====
// Operation
// - halving bit set makes afc tolerated frequency error half
// - afc config holds enable at bit 6 plus high and low gear fields
// - before preamble, correct every (short wait + 1) x 2 bit periods
// - short wait zero means no correction before preamble
// - after preamble, correct every (long wait + 1) x 2 bit periods
// - long wait zero means no correction after preamble
// - before preamble, loop gain is gain shifted right by fast value
// - preamble detection switches loop gain to slow shift automatically
// - direct mode immunity bit stored; software keeps it 0 in fifo mode
// - gearshift register: fast in bits 5:3, slow in bits 2:0
// - 11-bit oversampling ratio, 3 fraction bits, top bits at 7:5
// - 20-bit nco offset held across three registers
// - reset values give 40 kbps without manchester coding
// - gain bits 10:8 in upper gain reg, stall bit 4 of offset
// - low gain byte in next register, reset 10001111
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module afc_bit_clock_recovery_cfg
  import afc_bcr_pkg::*;
#(
  parameter int         BIT_CYC = BIT_CYCLES,
  parameter logic [7:0] AFC_TOL = AFC_TOL_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rd_data,
  input  wire logic        preamble_detected,
  input  wire logic        rx_restart,
  output logic             afc_enable,
  output logic      [7:0]  afc_err_tol,
  output logic      [2:0]  afc_gear_high,
  output logic      [2:0]  afc_gear_low,
  output logic             afc_update,
  output logic             preamble_phase,
  output logic      [10:0] bcr_gain,
  output logic      [2:0]  bcr_shift,
  output logic      [10:0] osr,
  output logic      [19:0] nco_offset,
  output logic             stall_ctrl,
  output logic             rx_ready_direct
);

  logic [7:0]  cfg_r, cfg_nxt;
  logic [5:0]  wait_r, wait_nxt;
  logic [7:0]  gear_r, gear_nxt;
  logic [7:0]  osr_lo_r, osr_lo_nxt;
  logic [7:0]  off_hi_r, off_hi_nxt;
  logic [7:0]  off_mid_r, off_mid_nxt;
  logic [7:0]  off_lo_r, off_lo_nxt;
  logic [7:0]  gain_hi_r, gain_hi_nxt;
  logic [7:0]  gain_lo_r, gain_lo_nxt;
  logic [7:0]  rd_data_r, rd_data_nxt;
  phase_t      phase_r, phase_nxt;
  logic [15:0] bit_cnt_r, bit_cnt_nxt;
  logic        half_r, half_nxt;
  logic [2:0]  pair_cnt_r, pair_cnt_nxt;
  logic        upd_r, upd_nxt;
  logic [10:0] gain_out_r, gain_out_nxt;
  logic [2:0]  active_wait;
  logic [10:0] gain_full;
  logic [2:0]  shift_sel;
  logic        tick_2tb;

  // one byte of the read mux; unmapped offsets answer zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      OFF_AFC_CONFIG:    read_mux = cfg_r;
      OFF_AFC_WAIT:      read_mux = {(phase_r == PH_LOCKED), 1'b0, wait_r};
      OFF_GEARSHIFT:     read_mux = gear_r;
      OFF_OSR_LOW:       read_mux = osr_lo_r;
      OFF_OFFSET_UPPER:  read_mux = off_hi_r;
      OFF_OFFSET_MIDDLE: read_mux = off_mid_r;
      OFF_OFFSET_LOWER:  read_mux = off_lo_r;
      OFF_GAIN_UPPER:    read_mux = gain_hi_r;
      OFF_GAIN_LOWER:    read_mux = gain_lo_r;
      default:           read_mux = 8'h00;
    endcase
  endfunction

  // register writes and the registered read answer
  always_comb begin
    cfg_nxt     = cfg_r;
    wait_nxt    = wait_r;
    gear_nxt    = gear_r;
    osr_lo_nxt  = osr_lo_r;
    off_hi_nxt  = off_hi_r;
    off_mid_nxt = off_mid_r;
    off_lo_nxt  = off_lo_r;
    gain_hi_nxt = gain_hi_r;
    gain_lo_nxt = gain_lo_r;
    rd_data_nxt = 8'h00; // data stands one cycle only
    if (wr_en) begin
      case (addr)
        OFF_AFC_CONFIG:    cfg_nxt     = wr_data;
        OFF_AFC_WAIT:      wait_nxt    = wr_data[5:0]; // top bits read only
        OFF_GEARSHIFT:     gear_nxt    = wr_data;
        OFF_OSR_LOW:       osr_lo_nxt  = wr_data;
        OFF_OFFSET_UPPER:  off_hi_nxt  = wr_data;
        OFF_OFFSET_MIDDLE: off_mid_nxt = wr_data;
        OFF_OFFSET_LOWER:  off_lo_nxt  = wr_data;
        OFF_GAIN_UPPER:    gain_hi_nxt = wr_data;
        OFF_GAIN_LOWER:    gain_lo_nxt = wr_data;
        default:           ;
      endcase
    end
    if (rd_en) begin
      rd_data_nxt = read_mux(addr);
    end
  end

  // reset values set 40 kbps without manchester
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r     <= RST_AFC_CONFIG;
      wait_r    <= RST_AFC_WAIT[5:0];
      gear_r    <= RST_GEARSHIFT;
      osr_lo_r  <= RST_OSR_LOW;
      off_hi_r  <= RST_OFFSET_UPPER;
      off_mid_r <= RST_OFFSET_MIDDLE;
      off_lo_r  <= RST_OFFSET_LOWER;
      gain_hi_r <= RST_GAIN_UPPER;
      gain_lo_r <= RST_GAIN_LOWER;
      rd_data_r <= 8'h00;
    end else begin
      cfg_r     <= cfg_nxt;
      wait_r    <= wait_nxt;
      gear_r    <= gear_nxt;
      osr_lo_r  <= osr_lo_nxt;
      off_hi_r  <= off_hi_nxt;
      off_mid_r <= off_mid_nxt;
      off_lo_r  <= off_lo_nxt;
      gain_hi_r <= gain_hi_nxt;
      gain_lo_r <= gain_lo_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // phase: preamble wins over a same-cycle restart so no detect is lost
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_SEARCH: if (preamble_detected) phase_nxt = PH_LOCKED;
      PH_LOCKED: if (rx_restart && !preamble_detected) begin
        phase_nxt = PH_SEARCH;
      end
      default:   phase_nxt = PH_SEARCH;
    endcase
  end

  // wait length follows the phase; zero blocks correction
  assign active_wait = (phase_r == PH_LOCKED) ?
                       wait_r[LGWAIT_LSB +: 3] :
                       wait_r[SHWAIT_LSB +: 3];
  assign tick_2tb = half_r && (bit_cnt_r == 16'(BIT_CYC - 1));

  // bit period divider and afc wait counter, restarted on phase change
  always_comb begin
    bit_cnt_nxt  = bit_cnt_r + 16'h0001;
    half_nxt     = half_r;
    pair_cnt_nxt = pair_cnt_r;
    upd_nxt      = 1'b0;
    if (bit_cnt_r == 16'(BIT_CYC - 1)) begin
      bit_cnt_nxt = 16'h0000;
      half_nxt    = ~half_r;
    end
    if (tick_2tb) begin
      if (pair_cnt_r >= active_wait) begin
        pair_cnt_nxt = 3'h0;
        // zero wait or disabled afc gives no pulse
        upd_nxt = cfg_r[AFC_ENABLE_BIT] && (active_wait != 3'h0);
      end else begin
        pair_cnt_nxt = pair_cnt_r + 3'h1;
      end
    end
    if (phase_nxt != phase_r) begin
      bit_cnt_nxt  = 16'h0000;
      half_nxt     = 1'b0;
      pair_cnt_nxt = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r    <= PH_SEARCH;
      bit_cnt_r  <= 16'h0000;
      half_r     <= 1'b0;
      pair_cnt_r <= 3'h0;
      upd_r      <= 1'b0;
      gain_out_r <= 11'h000;
    end else begin
      phase_r    <= phase_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      half_r     <= half_nxt;
      pair_cnt_r <= pair_cnt_nxt;
      upd_r      <= upd_nxt;
      gain_out_r <= gain_out_nxt;
    end
  end

  // loop gain shifted by the gear of the current phase
  assign gain_full = {gain_hi_r[GAIN_HI_LSB +: 3], gain_lo_r};
  assign shift_sel = (phase_r == PH_LOCKED) ?
                     gear_r[CRSLOW_LSB +: 3] :
                     gear_r[CRFAST_LSB +: 3];
  always_comb begin
    gain_out_nxt = gain_full >> shift_sel;
  end

  // outputs; config fields drive the loop directly
  assign rd_data         = rd_data_r;
  assign afc_enable      = cfg_r[AFC_ENABLE_BIT];
  assign afc_err_tol     = cfg_r[AFC_HALVE_BIT] ? (AFC_TOL >> 1) : AFC_TOL;
  assign afc_gear_high   = cfg_r[GEAR_HI_LSB +: 3];
  assign afc_gear_low    = cfg_r[GEAR_LO_LSB +: 3];
  assign afc_update      = upd_r;
  assign preamble_phase  = (phase_r == PH_LOCKED);
  assign bcr_gain        = gain_out_r;
  assign bcr_shift       = shift_sel;
  assign osr = {off_hi_r[OSR_HI_LSB +: 3], osr_lo_r};
  assign nco_offset = {off_hi_r[NCO_HI_LSB +: 4], off_mid_r, off_lo_r};
  assign stall_ctrl      = off_hi_r[STALL_BIT];
  assign rx_ready_direct = gear_r[RX_READY_BIT];

  // helper: 2-bit-period ticks since the last correction in this phase
  logic [3:0] ticks_seen_r;
  logic       prev_phase_r;
  logic       clean_r; // no wait or enable write since last pulse or phase change
  // a mid-count field write spoils one spacing, so that gap is not judged
  always_ff @(posedge clk) begin
    if (rst) begin
      ticks_seen_r <= 4'h0;
      prev_phase_r <= 1'b0;
      clean_r      <= 1'b1;
    end else begin
      prev_phase_r <= preamble_phase;
      if (wr_en && (addr == OFF_AFC_WAIT || addr == OFF_AFC_CONFIG)) begin
        clean_r <= 1'b0;
      end else if (upd_r || (phase_nxt != phase_r)) begin
        clean_r <= 1'b1;
      end
      if (upd_r || (phase_nxt != phase_r)) ticks_seen_r <= 4'h0;
      else if (tick_2tb) ticks_seen_r <= ticks_seen_r + 4'h1;
    end
  end

  tol_halved_a: assert property (@(posedge clk) disable iff (rst)
    cfg_r[AFC_HALVE_BIT] |-> afc_err_tol == (AFC_TOL >> 1))
    else $error("tolerance not halved");

  afc_enable_a: assert property (@(posedge clk) disable iff (rst)
    !afc_enable |-> ##1 !afc_update)
    else $error("afc update while disabled");

  short_wait_a: assert property (@(posedge clk) disable iff (rst)
    (afc_update && !prev_phase_r && !preamble_phase && clean_r) |->
    ticks_seen_r == 4'(wait_r[SHWAIT_LSB +: 3]) + 4'h1)
    else $error("short wait spacing wrong");

  no_short_a: assert property (@(posedge clk) disable iff (rst)
    (phase_r == PH_SEARCH && wait_r[SHWAIT_LSB +: 3] == 3'h0) |=>
    !afc_update || $past(phase_r) != PH_SEARCH)
    else $error("correction with short wait zero");

  long_wait_a: assert property (@(posedge clk) disable iff (rst)
    (afc_update && prev_phase_r && preamble_phase && clean_r) |->
    ticks_seen_r == 4'(wait_r[LGWAIT_LSB +: 3]) + 4'h1)
    else $error("long wait spacing wrong");

  no_long_a: assert property (@(posedge clk) disable iff (rst)
    (phase_r == PH_LOCKED && wait_r[LGWAIT_LSB +: 3] == 3'h0) |=>
    !afc_update || $past(phase_r) != PH_LOCKED)
    else $error("correction with long wait zero");

  fast_gain_a: assert property (@(posedge clk) disable iff (rst)
    (phase_r == PH_SEARCH) ##1 (phase_r == PH_SEARCH) |->
    bcr_gain == ($past(gain_full) >> $past(gear_r[CRFAST_LSB +: 3])))
    else $error("fast gain wrong");

  slow_switch_a: assert property (@(posedge clk) disable iff (rst)
    preamble_detected |=> preamble_phase ##1
    bcr_gain == ($past(gain_full) >> $past(gear_r[CRSLOW_LSB +: 3])))
    else $error("slow gain not applied");

  nco_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == OFF_OFFSET_MIDDLE) |=> rd_data == nco_offset[15:8])
    else $error("nco middle readback wrong");

  osr_reset_a: assert property (@(posedge clk)
    rst |=> osr == 11'h064 && nco_offset == 20'h147AE)
    else $error("reset rate values wrong");

  gain_reset_a: assert property (@(posedge clk)
    (rst ##1 !rst) |=> bcr_gain == 11'h08F)
    else $error("gain low reset wrong");

  restart_a: assert property (@(posedge clk) disable iff (rst)
    (rx_restart && !preamble_detected) |=> !preamble_phase)
    else $error("restart did not revert phase");

  // write paths of the gearshift, oversampling and gain bytes
  gear_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == OFF_GEARSHIFT && !preamble_phase &&
     !preamble_detected) |=> bcr_shift == $past(wr_data[CRFAST_LSB +: 3]))
    else $error("fast gear field misplaced");

  osr_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == OFF_OSR_LOW) |=> osr[7:0] == $past(wr_data))
    else $error("osr low byte not applied");

  stall_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == OFF_OFFSET_UPPER) |=> stall_ctrl == $past(wr_data[4])
    && osr[10:8] == $past(wr_data[OSR_HI_LSB +: 3]))
    else $error("offset upper fields misplaced");

  gain_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == OFF_GAIN_UPPER) |=> gain_full[10:8] == $past(wr_data[2:0]))
    else $error("gain upper bits misplaced");

  // phase readback; bit 6 of the wait byte always reads zero
  phase_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == OFF_AFC_WAIT) |=> rd_data[7:6] == {$past(preamble_phase), 1'b0})
    else $error("wait byte top bits wrong");

  search_upd_c: cover property (@(posedge clk) disable iff (rst)
    !preamble_phase && afc_update);
  locked_upd_c: cover property (@(posedge clk) disable iff (rst)
    preamble_phase && afc_update);
  detect_c: cover property (@(posedge clk) disable iff (rst)
    preamble_detected ##1 preamble_phase);
  restart_c: cover property (@(posedge clk) disable iff (rst)
    preamble_phase ##1 rx_restart ##1 !preamble_phase);
  gear_rec_c: cover property (@(posedge clk) disable iff (rst)
    gear_r[5:0] == 6'h05 && preamble_phase);

endmodule // afc_bit_clock_recovery_cfg

// ==== tb/afc_and_bit_clock_recovery_cfg_tb.sv ====
`timescale 1ns/100ps
module afc_and_bit_clock_recovery_cfg_tb;
  import afc_bcr_pkg::*;
  localparam int BC = 4; // short bit period keeps the timer runs brief
  logic        clk, rst, wr_en, rd_en, preamble_detected, rx_restart;
  logic [7:0]  addr, wr_data, rd_data, afc_err_tol, d;
  logic [2:0]  afc_gear_high, afc_gear_low, bcr_shift;
  logic        afc_enable, afc_update, preamble_phase, stall_ctrl;
  logic        rx_ready_direct;
  logic [10:0] bcr_gain, osr;
  logic [19:0] nco_offset;
  int          mismatches, checks_done, cycles;

  afc_bit_clock_recovery_cfg #(.BIT_CYC(BC)) DUT (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .preamble_detected(preamble_detected), .rx_restart(rx_restart),
    .afc_enable(afc_enable), .afc_err_tol(afc_err_tol),
    .afc_gear_high(afc_gear_high), .afc_gear_low(afc_gear_low),
    .afc_update(afc_update), .preamble_phase(preamble_phase),
    .bcr_gain(bcr_gain), .bcr_shift(bcr_shift), .osr(osr),
    .nco_offset(nco_offset), .stall_ctrl(stall_ctrl),
    .rx_ready_direct(rx_ready_direct));

  // clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string what, input logic [19:0] exp,
                     input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask

  // one-cycle strobe: preamble_detected when det, else rx_restart
  task automatic pulse(input logic det);
    @(posedge clk);
    if (det) preamble_detected <= 1'b1;
    else rx_restart <= 1'b1;
    @(posedge clk);
    preamble_detected <= 1'b0;
    rx_restart <= 1'b0;
    #1;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    logic [7:0] offs[9] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22,
                            8'h23, 8'h24, 8'h25};
    logic [7:0] vals[9] = '{8'h40, 8'h0A, 8'h03, 8'h64, 8'h01, 8'h47,
                            8'hAE, 8'h00, 8'h8F};
    for (int i = 0; i < 9; i++) begin
      rd(offs[i], d);
      chk("reset value", {12'h000, vals[i]}, {12'h000, d});
    end
    rd(8'h26, d);
    chk("unmapped read", 20'h00000, {12'h000, d});
    chk("osr", 20'h00064, {9'h000, osr});
    chk("nco", 20'h147AE, nco_offset);
    chk("gain", 20'h0008F, {9'h000, bcr_gain});
  endtask

  task automatic t_afc_cfg();
    wr(8'h1D, 8'hEA);
    chk("tolerance", {12'h000, 8'h20}, {12'h000, afc_err_tol});
    chk("enable", 20'h1, {19'h0, afc_enable});
    chk("gear high", 20'h5, {17'h0, afc_gear_high});
    chk("gear low", 20'h2, {17'h0, afc_gear_low});
    wr(8'h1D, 8'h15);
    chk("tolerance", {12'h000, 8'h40}, {12'h000, afc_err_tol});
    chk("enable", 20'h0, {19'h0, afc_enable});
    rd(8'h1D, d);
    chk("cfg readback", 20'h15, {12'h000, d});
  endtask

  // fast shift 5, slow shift 0, so the two phases differ sharply
  task automatic t_gear();
    wr(8'h24, 8'h07);
    wr(8'h25, 8'hFF);
    wr(8'h1F, 8'h68);
    settle();
    chk("shift search", 20'h5, {17'h0, bcr_shift});
    chk("gain search", 20'h0003F, {9'h0, bcr_gain});
    chk("rx ready", 20'h1, {19'h0, rx_ready_direct});
    pulse(1'b1);
    chk("phase", 20'h1, {19'h0, preamble_phase});
    settle();
    chk("gain locked", 20'h007FF, {9'h0, bcr_gain});
    rd(8'h1E, d);
    chk("phase readback", 20'h1, {19'h0, d[7]});
    pulse(1'b0);
    settle();
    chk("phase", 20'h0, {19'h0, preamble_phase});
    chk("gain search", 20'h0003F, {9'h0, bcr_gain});
    wr(8'h1F, 8'h05);
    settle();
    chk("shift rec", 20'h0, {17'h0, bcr_shift});
    chk("gain rec", 20'h007FF, {9'h0, bcr_gain});
    chk("rx ready", 20'h0, {19'h0, rx_ready_direct});
    pulse(1'b1);
    settle();
    chk("gain rec locked", 20'h0003F, {9'h0, bcr_gain});
    pulse(1'b0);
  endtask

  task automatic t_osr();
    wr(8'h21, 8'hB5);
    wr(8'h20, 8'h3C);
    wr(8'h22, 8'h12);
    wr(8'h23, 8'h9A);
    chk("osr", 20'h0053C, {9'h0, osr});
    chk("nco", 20'h5129A, nco_offset);
    chk("stall", 20'h1, {19'h0, stall_ctrl});
    wr(8'h1E, 8'hFF);
    rd(8'h1E, d);
    chk("wait readback", 20'h3F, {12'h000, d});
    wr(8'h26, 8'h55);
    rd(8'h26, d);
    chk("unmapped write", 20'h00000, {12'h000, d});
  endtask

  task automatic gap(input int exp);
    int n;
    n = 0;
    while (afc_update !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (afc_update !== 1'b1 && n < 200);
    chk("update gap", exp, n);
  endtask

  task automatic no_pulse(input int len);
    int seen;
    seen = 0;
    repeat (len) begin
      @(posedge clk);
      #1;
      if (afc_update === 1'b1) seen++;
    end
    chk("update count", 20'h0, seen);
  endtask

  // first gap after a field change is skipped by gap itself
  task automatic t_timer();
    wr(8'h1D, 8'h40);
    wr(8'h1E, 8'h08);
    gap(2 * 2 * BC);
    pulse(1'b1);
    no_pulse(60);
    wr(8'h1E, 8'h0A);
    gap(3 * 2 * BC);
    pulse(1'b0);
    wr(8'h1E, 8'h02);
    no_pulse(60);
    wr(8'h1E, 8'h08);
    wr(8'h1D, 8'h00);
    no_pulse(60);
  endtask

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    preamble_detected = 1'b0;
    rx_restart = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_afc_cfg();
    t_gear();
    t_osr();
    t_timer();
    results();
  end
endmodule // afc_and_bit_clock_recovery_cfg_tb
